/* File: rtl/upc_regs.svh */
// register map constants for the upconverter register bank
`ifndef UPC_REGS_SVH
`define UPC_REGS_SVH
// ****************************************
// serial addresses
// ****************************************
`define UPC_ADDR_CTRL1 5'h00
`define UPC_ADDR_PROF7 5'h15
`define UPC_ADDR_RAM 5'h16
`define UPC_ADDR_PINCFG 5'h18
`define UPC_ADDR_PINDAT 5'h19
`define UPC_ADDR_LAST 5'h19
// ****************************************
// byte lengths per address
// ****************************************
`define UPC_LEN_CTRL1 4'h4
`define UPC_LEN_PROF7 4'h8
`define UPC_LEN_RAM 4'h4
`define UPC_LEN_PIN 4'h2
`define UPC_LEN_DEFAULT 4'h4
// ****************************************
// field positions in profile slot seven
// ****************************************
`define UPC_P7_AMP_HI 61
`define UPC_P7_AMP_LO 48
`define UPC_P7_PHASE_HI 47
`define UPC_P7_PHASE_LO 32
`define UPC_P7_FREQ_HI 31
`define UPC_P7_FREQ_LO 0
`define UPC_P7_RATE_HI 63
`define UPC_P7_RATE_LO 58
`define UPC_P7_INVERT 57
`define UPC_P7_BYPASS 56
`define UPC_P7_OSCALE_HI 55
`define UPC_P7_OSCALE_LO 48
// ****************************************
// reset values
// ****************************************
`define UPC_RST_64 64'h0000000000000000
`endif

/* File: rtl/upc_pkg.sv */
// types shared by the upconverter register bank
package upc_pkg;
   typedef enum logic [1:0] {UPC_IDLE, UPC_ADDR, UPC_DATA} upc_state_t;
   typedef logic [63:0] upc_word_t;
endpackage

/* File: rtl/upc_sync.sv */
// three-stage synchroniser for serial port pins
`timescale 1ns/1ns
`default_nettype none
module upc_sync #(
   parameter int WIDTH = 3
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] s1, s2, s3, held;
   logic [WIDTH-1:0] next_held;
   always_comb begin
      next_held = held;
      for (int i = 0; i < WIDTH; i++) begin
         // accept a change only once stages two and three agree
         if (s2[i] == s3[i]) begin
            next_held[i] = s2[i];
         end
      end
   end
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         held <= '0;
      end else begin
         s1 <= async_in;
         s2 <= s1;
         s3 <= s2;
         held <= next_held;
      end
   end
   assign sync_out = held;
endmodule // upc_sync
`default_nettype wire

/* File: rtl/upc_stage.sv */
// staging buffer with transfer on update or profile change
`timescale 1ns/1ns
`default_nettype none
module upc_stage #(
   parameter int WIDTH = 32
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic apply,
   output logic [WIDTH-1:0] staged,
   output logic [WIDTH-1:0] active
);
   logic [WIDTH-1:0] next_staged, next_active;
   always_comb begin
      next_staged = wr_en ? wr_data : staged;
      // live copy moves only on apply (update or profile change), so multi-register changes land together
      next_active = apply ? next_staged : active; // [R7]
   end
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         staged <= '0;
         active <= '0;
      end else begin
         staged <= next_staged;
         active <= next_active;
      end
   end
endmodule // upc_stage
`default_nettype wire

/* File: rtl/upc_regbank.sv */
// serial port register bank of the upconverter, tail of the map
// Summary of operation
// [R1] profile slot seven at 0x15 holds 64 bits with tone and quadrature field views.
// [R2] the ram access word at 0x16 moves one 32-bit word per serial access.
// [R3] pin direction config at 0x18 and pin data at 0x19 are 16 bits each.
// [R4] addresses 0x00 to 0x19 exist, with 0x07, 0x08, 0x0b to 0x0d and 0x17 unused.
// [R5] each register has its own byte length and the host shifts exactly that many bytes.
// [R6] a multi-bit field is one binary word, msb first, bit 0 the register lsb.
// [R7] written values, except the ram word at 0x16, wait in staging until an io update or profile change.
// [R8] control word one sits at 0x00 and is four bytes long.
// [R9] unused addresses change nothing and read back as zeros.
`timescale 1ns/1ns
`default_nettype none
`include "upc_regs.svh"
module upc_regbank
   import upc_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdio_in,
   output logic sdio_out,
   output logic sdio_oe,
   input wire logic io_update,
   input wire logic [2:0] profile_sel,
   output logic [31:0] control_word_one,
   output logic [13:0] tone_amplitude,
   output logic [15:0] tone_phase,
   output logic [31:0] tone_frequency,
   output logic [5:0] quadrature_upconvert_view_rate,
   output logic quadrature_upconvert_view_invert,
   output logic quadrature_upconvert_view_bypass,
   output logic [7:0] quadrature_upconvert_view_scale,
   output logic [31:0] ram_word,
   output logic ram_word_strobe,
   output logic [15:0] pin_direction_config,
   output logic [15:0] pin_data_value
);
   // ****************************************
   // decode helpers
   // ****************************************
   // unused addresses and anything above the top of the map are holes
   function automatic logic upc_used(input logic [4:0] a);
      upc_used = !(a == 5'h07 || a == 5'h08 || (a >= 5'h0b && a <= 5'h0d)
                   || a == 5'h17 || a > `UPC_ADDR_LAST); // [R4]
   endfunction
   function automatic logic [3:0] upc_len(input logic [4:0] a);
      case (a)
         `UPC_ADDR_CTRL1: upc_len = `UPC_LEN_CTRL1; // [R8]
         `UPC_ADDR_PROF7: upc_len = `UPC_LEN_PROF7; // [R1]
         `UPC_ADDR_RAM: upc_len = `UPC_LEN_RAM; // [R2]
         `UPC_ADDR_PINCFG: upc_len = `UPC_LEN_PIN; // [R3]
         `UPC_ADDR_PINDAT: upc_len = `UPC_LEN_PIN; // [R3]
         // holes take the common four-byte frame so the host can still probe them
         default: upc_len = `UPC_LEN_DEFAULT;
      endcase
   endfunction
   // ****************************************
   // pin synchronisation
   // ****************************************
   // chip select enters inverted so the synchroniser reset state reads as deselected
   logic [2:0] pins;
   upc_sync #(.WIDTH(3)) u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .async_in({sclk, ~cs_n, sdio_in}),
      .sync_out(pins)
   );
   logic sclk_s, cs_s_n, sdi_s;
   assign sclk_s = pins[2];
   assign cs_s_n = !pins[1];
   assign sdi_s = pins[0];
   // ****************************************
   // serial shifter state
   // ****************************************
   upc_state_t state, next_state;
   logic sclk_d, next_sclk_d;
   logic [5:0] bit_cnt, next_bit_cnt;
   logic [4:0] addr, next_addr;
   logic rd, next_rd;
   logic [63:0] shift_in, next_shift_in;
   logic [63:0] shift_out, next_shift_out;
   logic dout, next_dout;
   logic oe, next_oe;
   logic wr_pulse, next_wr_pulse;
   logic [2:0] prof_d, next_prof_d;
   logic upd_d, next_upd_d;
   logic done, next_done;
   logic [63:0] rd_value;
   logic rise, fall;
   logic [6:0] nbits;
   logic [63:0] prof7_staged, prof7_active;
   logic [31:0] ctrl_staged, ram_staged;
   logic [15:0] cfg_staged, dat_staged;
   logic apply;
   logic wr_ctrl, wr_prof7, wr_cfg, wr_dat;
   // ****************************************
   // edge detect and frame length
   // ****************************************
   assign rise = sclk_s && !sclk_d;
   assign fall = !sclk_s && sclk_d;
   assign nbits = {upc_len(addr), 3'h0}; // [R5]
   // readback; bits of a narrow register sit low, msb shifted first
   always_comb begin
      rd_value = 64'h0000000000000000;
      case (addr)
         `UPC_ADDR_CTRL1: rd_value = {32'h00000000, ctrl_staged};
         `UPC_ADDR_PROF7: rd_value = prof7_staged;
         `UPC_ADDR_RAM: rd_value = {32'h00000000, ram_staged};
         `UPC_ADDR_PINCFG: rd_value = {48'h000000000000, cfg_staged};
         `UPC_ADDR_PINDAT: rd_value = {48'h000000000000, dat_staged};
         default: rd_value = 64'h0000000000000000; // [R9]
      endcase
   end
   // ****************************************
   // next state of the shifter
   // ****************************************
   always_comb begin
      next_state = state;
      next_sclk_d = sclk_s;
      next_bit_cnt = bit_cnt;
      next_addr = addr;
      next_rd = rd;
      next_shift_in = shift_in;
      next_shift_out = shift_out;
      next_dout = dout;
      next_oe = oe;
      next_wr_pulse = 1'b0;
      next_prof_d = profile_sel;
      next_upd_d = io_update;
      next_done = done;
      if (cs_s_n) begin
         // release sdio as soon as the frame closes
         next_state = UPC_IDLE;
         next_oe = 1'b0;
         next_done = 1'b0;
      end else begin
         case (state)
            UPC_IDLE: begin
               // bits past the register length wait out the frame unread
               if (!done) begin
                  next_state = UPC_ADDR;
                  next_bit_cnt = 6'h00;
               end
            end
            UPC_ADDR: begin
               if (rise) begin
                  // instruction byte: read flag, two spare bits, five address bits
                  next_shift_in = {shift_in[62:0], sdi_s};
                  next_bit_cnt = bit_cnt + 6'h01;
                  if (bit_cnt == 6'h07) begin
                     next_rd = shift_in[6];
                     next_addr = {shift_in[3:0], sdi_s};
                     next_bit_cnt = 6'h00;
                     next_state = UPC_DATA;
                  end
               end
            end
            UPC_DATA: begin
               if (bit_cnt == 6'h00 && !oe && rd) begin
                  next_shift_out = rd_value << (7'd64 - nbits);
                  next_oe = 1'b1;
                  next_dout = next_shift_out[63];
               end
               if (rise) begin
                  next_shift_in = {shift_in[62:0], sdi_s}; // [R6]
                  next_bit_cnt = bit_cnt + 6'h01;
                  if ({1'b0, bit_cnt} == nbits - 7'd1) begin
                     // exact length only; a short frame writes nothing
                     next_wr_pulse = !rd && upc_used(addr); // [R5] [R9]
                     next_state = UPC_IDLE;
                     next_done = 1'b1;
                  end
               end
               // the fall that closes the instruction byte must not skip the first bit
               if (fall && rd && oe && bit_cnt != 6'h00) begin
                  next_shift_out = {shift_out[62:0], 1'b0};
                  next_dout = shift_out[62];
               end
            end
            default: next_state = UPC_IDLE;
         endcase
      end
   end
   // ****************************************
   // shifter registers
   // ****************************************
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state <= UPC_IDLE;
         sclk_d <= 1'b0;
         bit_cnt <= 6'h00;
         addr <= 5'h00;
         rd <= 1'b0;
         shift_in <= `UPC_RST_64;
         shift_out <= `UPC_RST_64;
         dout <= 1'b0;
         oe <= 1'b0;
         wr_pulse <= 1'b0;
         prof_d <= 3'h0;
         upd_d <= 1'b0;
         done <= 1'b0;
      end else begin
         state <= next_state;
         sclk_d <= next_sclk_d;
         bit_cnt <= next_bit_cnt;
         addr <= next_addr;
         rd <= next_rd;
         shift_in <= next_shift_in;
         shift_out <= next_shift_out;
         dout <= next_dout;
         oe <= next_oe;
         wr_pulse <= next_wr_pulse;
         prof_d <= next_prof_d;
         upd_d <= next_upd_d;
         done <= next_done;
      end
   end
   // ****************************************
   // write decode and staging
   // ****************************************
   // io_update is same-clock logic; its rising edge or a profile change applies
   // a held io_update applies once, so later writes stay staged
   assign apply = (io_update && !upd_d) || (profile_sel != prof_d); // [R7]
   // a write to a hole decodes to none of these strobes
   assign wr_ctrl = wr_pulse && addr == `UPC_ADDR_CTRL1; // [R8]
   assign wr_prof7 = wr_pulse && addr == `UPC_ADDR_PROF7; // [R1]
   assign wr_cfg = wr_pulse && addr == `UPC_ADDR_PINCFG; // [R3]
   assign wr_dat = wr_pulse && addr == `UPC_ADDR_PINDAT; // [R3]
   upc_stage #(.WIDTH(32)) u_ctrl (
      .clock(clock),
      .rst_n(rst_n),
      .wr_en(wr_ctrl),
      .wr_data(shift_in[31:0]),
      .apply(apply),
      .staged(ctrl_staged),
      .active(control_word_one)
   );
   upc_stage #(.WIDTH(64)) u_prof7 (
      .clock(clock),
      .rst_n(rst_n),
      .wr_en(wr_prof7),
      .wr_data(shift_in),
      .apply(apply),
      .staged(prof7_staged),
      .active(prof7_active)
   );
   upc_stage #(.WIDTH(16)) u_cfg (
      .clock(clock),
      .rst_n(rst_n),
      .wr_en(wr_cfg),
      .wr_data(shift_in[15:0]),
      .apply(apply),
      .staged(cfg_staged),
      .active(pin_direction_config)
   );
   upc_stage #(.WIDTH(16)) u_dat (
      .clock(clock),
      .rst_n(rst_n),
      .wr_en(wr_dat),
      .wr_data(shift_in[15:0]),
      .apply(apply),
      .staged(dat_staged),
      .active(pin_data_value)
   );
   // ram word is not staged: each write access hands one word straight to the ram
   logic [31:0] next_ram_staged;
   logic next_ram_strobe;
   always_comb begin
      next_ram_strobe = wr_pulse && addr == `UPC_ADDR_RAM; // [R2]
      next_ram_staged = next_ram_strobe ? shift_in[31:0] : ram_staged;
   end
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ram_staged <= 32'h00000000;
         ram_word_strobe <= 1'b0;
      end else begin
         ram_staged <= next_ram_staged;
         ram_word_strobe <= next_ram_strobe;
      end
   end
   assign ram_word = ram_staged;
   // ****************************************
   // field views of profile slot seven
   // ****************************************
   assign tone_amplitude = prof7_active[`UPC_P7_AMP_HI:`UPC_P7_AMP_LO]; // [R1]
   assign tone_phase = prof7_active[`UPC_P7_PHASE_HI:`UPC_P7_PHASE_LO]; // [R1]
   assign tone_frequency = prof7_active[`UPC_P7_FREQ_HI:`UPC_P7_FREQ_LO]; // [R1]
   assign quadrature_upconvert_view_rate =
      prof7_active[`UPC_P7_RATE_HI:`UPC_P7_RATE_LO]; // [R1]
   assign quadrature_upconvert_view_invert = prof7_active[`UPC_P7_INVERT]; // [R1]
   assign quadrature_upconvert_view_bypass = prof7_active[`UPC_P7_BYPASS]; // [R1]
   assign quadrature_upconvert_view_scale =
      prof7_active[`UPC_P7_OSCALE_HI:`UPC_P7_OSCALE_LO]; // [R1]
   // ****************************************
   // pin outputs
   // ****************************************
   assign sdio_out = dout;
   assign sdio_oe = oe;
endmodule // upc_regbank
`default_nettype wire

/* File: bench/upc_regbank_checker.sv */
// assertions on the ports of the upconverter register bank
`timescale 1ns/1ns
`default_nettype none
module upc_regbank_checker (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic io_update,
   input wire logic [2:0] profile_sel,
   input wire logic sdio_oe,
   input wire logic [31:0] control_word_one,
   input wire logic [13:0] tone_amplitude,
   input wire logic [31:0] tone_frequency,
   input wire logic [5:0] quadrature_upconvert_view_rate,
   input wire logic quadrature_upconvert_view_invert,
   input wire logic quadrature_upconvert_view_bypass,
   input wire logic [7:0] quadrature_upconvert_view_scale,
   input wire logic [31:0] ram_word,
   input wire logic ram_word_strobe,
   input wire logic [15:0] pin_direction_config,
   input wire logic [15:0] pin_data_value
);
   logic io_q;
   logic [2:0] prof_q;
   logic hit_q;
   logic hit;
   // apply seen one or two edges ago; live outputs may move only then
   always_ff @(posedge clock) begin
      io_q <= io_update;
      prof_q <= profile_sel;
      hit_q <= (io_update & ~io_q) | (profile_sel != prof_q);
   end
   assign hit = hit_q;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence cs_idle;
      cs_n [*6];
   endsequence
   a_ctrl_staged: assert property (
      $changed(control_word_one) |-> hit || $past(hit))
      else $error("control word moved without apply");
   a_prof_staged: assert property (
      $changed({tone_amplitude, tone_frequency}) |-> hit || $past(hit))
      else $error("profile moved without apply");
   a_cfg_staged: assert property (
      $changed(pin_direction_config) |-> hit || $past(hit))
      else $error("pin config moved without apply");
   a_data_staged: assert property (
      $changed(pin_data_value) |-> hit || $past(hit))
      else $error("pin data moved without apply");
   a_strobe_pulse: assert property (ram_word_strobe |=> !ram_word_strobe)
      else $error("ram strobe longer than one cycle");
   a_ram_on_strobe: assert property (
      $changed(ram_word) |-> ram_word_strobe || $past(ram_word_strobe))
      else $error("ram word moved without strobe");
   a_views_overlap: assert property (
      tone_amplitude == {quadrature_upconvert_view_rate[3:0],
      quadrature_upconvert_view_invert, quadrature_upconvert_view_bypass,
      quadrature_upconvert_view_scale})
      else $error("tone and quadrature views disagree");
   a_oe_released: assert property (cs_idle |-> !sdio_oe)
      else $error("sdio driven outside a frame");
endmodule // upc_regbank_checker
bind upc_regbank upc_regbank_checker chk (.clock(clock), .rst_n(rst_n), .cs_n(cs_n),
   .io_update(io_update), .profile_sel(profile_sel), .sdio_oe(sdio_oe),
   .control_word_one(control_word_one), .tone_amplitude(tone_amplitude),
   .tone_frequency(tone_frequency),
   .quadrature_upconvert_view_rate(quadrature_upconvert_view_rate),
   .quadrature_upconvert_view_invert(quadrature_upconvert_view_invert),
   .quadrature_upconvert_view_bypass(quadrature_upconvert_view_bypass),
   .quadrature_upconvert_view_scale(quadrature_upconvert_view_scale), .ram_word(ram_word),
   .ram_word_strobe(ram_word_strobe), .pin_direction_config(pin_direction_config),
   .pin_data_value(pin_data_value));
`default_nettype wire

/* File: bench/upc_host_model.sv */
// host controller model driving the serial port
`timescale 1ns/1ns
`default_nettype none
module upc_host_model (
   input wire logic clock,
   output logic sclk,
   output logic cs_n,
   output logic sdio_in,
   input wire logic sdio_out
);
   // sclk half period in clocks, kept above four so the synchroniser keeps up
   localparam int HALF = 8;
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdio_in = 1'b0;
   end
   task automatic half_wait();
      repeat (HALF) @(posedge clock);
      #1;
   endtask
   // one register per frame; sclk stands still low outside frames
   task automatic xfer(input logic rd, input logic [4:0] addr, input int nbits,
                       input logic [63:0] wdata, output logic [63:0] rdata);
      logic [7:0] instr;
      instr = {rd, 2'b00, addr};
      rdata = 64'h0;
      cs_n = 1'b0;
      for (int i = 0; i < 8 + nbits; i++) begin
         if (i < 8) sdio_in = instr[7-i];
         else if (rd) sdio_in = ~sdio_in;
         else sdio_in = wdata[nbits-1-(i-8)];
         half_wait();
         if (i >= 8) rdata = {rdata[62:0], sdio_out};
         sclk = 1'b1;
         half_wait();
         sclk = 1'b0;
      end
      half_wait();
      cs_n = 1'b1;
      sdio_in = ~sdio_in; // released line shows no stale value
      half_wait();
   endtask
endmodule // upc_host_model
`default_nettype wire

/* File: bench/tb.sv */
// self-checking bench of the upconverter register bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
   $display("MISMATCH %s exp=%h got=%h", nm, e, g); end end
module tb;
   localparam int LIMIT = 60000;
   localparam logic [63:0] P = 64'hd5a7_1234_89ab_cdef;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic io_update = 1'b0;
   logic [2:0] profile_sel = 3'h0;
   logic sclk, cs_n, sdio_in, sdio_out, sdio_oe, strobe, inv, byp;
   logic [31:0] cw1, freq, ram;
   logic [13:0] amp;
   logic [15:0] phase, pcfg, pdat;
   logic [5:0] rate;
   logic [7:0] scale;
   logic [63:0] rdat;
   logic [4:0] unused_addr [7] = '{5'h07, 5'h08, 5'h0b, 5'h0c, 5'h0d, 5'h17, 5'h1a};
   int n_fail = 0;
   int check_count = 0;
   int cycles = 0;
   int strobes = 0;
   always #5 clock = ~clock;
   upc_host_model host (.clock(clock), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
      .sdio_out(sdio_out));
   upc_regbank dut (.clock(clock), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
      .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .io_update(io_update),
      .profile_sel(profile_sel), .control_word_one(cw1), .tone_amplitude(amp),
      .tone_phase(phase), .tone_frequency(freq), .quadrature_upconvert_view_rate(rate),
      .quadrature_upconvert_view_invert(inv), .quadrature_upconvert_view_bypass(byp),
      .quadrature_upconvert_view_scale(scale), .ram_word(ram), .ram_word_strobe(strobe),
      .pin_direction_config(pcfg), .pin_data_value(pdat));
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (strobe === 1'b1) strobes++;
      if (cycles == LIMIT) begin
         n_fail++;
         tally_and_finish();
      end
   end
   task automatic wr(input logic [4:0] a, input int n, input logic [63:0] d);
      host.xfer(1'b0, a, n, d, rdat);
   endtask
   task automatic rchk(input logic [4:0] a, input int n, input logic [63:0] e);
      host.xfer(1'b1, a, n, 64'h0, rdat);
      `CHK("readback", e, rdat)
      `CHK("oe released", 1'b0, sdio_oe)
   endtask
   task automatic apply_io();
      io_update = 1'b1;
      @(posedge clock);
      #1;
      io_update = 1'b0;
      repeat (3) @(posedge clock);
      #1;
   endtask
   initial begin
      repeat (10) @(posedge clock);
      #1;
      rst_n = 1'b1;
      repeat (6) @(posedge clock);
      #1;
      `CHK("pin data reset", 16'h0, pdat)
      wr(5'h19, 16, 64'habcd);
      `CHK("pin data staged", 16'h0, pdat)
      apply_io();
      `CHK("pin data", 16'habcd, pdat)
      wr(5'h18, 16, 64'h1234);
      wr(5'h00, 32, 64'h89ab_cdef);
      wr(5'h15, 64, P);
      `CHK("control staged", 32'h0, cw1)
      // profile change alone must apply everything staged
      profile_sel = 3'h3;
      repeat (3) @(posedge clock);
      #1;
      `CHK("pin config", 16'h1234, pcfg)
      `CHK("control word", 32'h89abcdef, cw1)
      `CHK("amplitude", P[61:48], amp)
      `CHK("phase", P[47:32], phase)
      `CHK("frequency", P[31:0], freq)
      `CHK("quad fields", P[63:48], {rate, inv, byp, scale})
      rchk(5'h00, 32, 64'h89ab_cdef);
      rchk(5'h15, 64, P);
      rchk(5'h18, 16, 64'h1234);
      rchk(5'h19, 16, 64'habcd);
      wr(5'h16, 32, 64'hcafe_f00d);
      `CHK("ram word", 32'hcafef00d, ram)
      foreach (unused_addr[i]) begin
         wr(unused_addr[i], 32, 64'hffff_ffff);
         rchk(unused_addr[i], 32, 64'h0);
      end
      wr(5'h19, 8, 64'h55);
      apply_io();
      `CHK("pin data kept", 16'habcd, pdat)
      `CHK("control kept", 32'h89abcdef, cw1)
      `CHK("ram strobes", 1, strobes)
      tally_and_finish();
   end
endmodule // tb
`default_nettype wire
